// ### src/ppac_pkg.sv
// Constants, types and register map of the page protection controller.
// Assumes one 250 MHz clock and an APB register bus.
package ppac_pkg;

  // --------------------------------------------------------------------
  // Memory geometry
  // --------------------------------------------------------------------
  localparam int PAGES = 16;
  localparam int BLK_PER_PAGE = 8;
  localparam int WORD_W = 32;
  localparam int PAGE_W = 4;
  localparam int BLK_W = 3;
  localparam int MADDR_W = PAGE_W + BLK_W;
  localparam int MEM_WORDS = PAGES * BLK_PER_PAGE;
  localparam int SCR_WORDS = 8;

  // --------------------------------------------------------------------
  // Protection bits of one page
  // --------------------------------------------------------------------
  localparam int PROT_W = 4;
  localparam int PROT_RD_BIT = 0;
  localparam int PROT_WR_BIT = 1;
  localparam int PROT_OTP_BIT = 2;
  localparam int PROT_AUTH_BIT = 3;
  localparam logic [PAGES*PROT_W-1:0] PROT_RST = 64'h0000000000000000;

  // --------------------------------------------------------------------
  // Register byte offsets and fields
  // --------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [7:0] OFF_PROT_NEW = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_PROT_CUR = 8'h20;
  localparam logic [2:0] OFF_SCR_HI = 3'h2;
  localparam int CTRL_START_BIT = 3;
  localparam int ADDR_PAGE_LSB = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_HASH_BIT = 1;
  localparam int STAT_PROG_BIT = 2;
  localparam int STAT_ERR_LSB = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
  localparam logic [WORD_W-1:0] WORD_RST = 32'h00000000;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int HASH_MAX_MS = 2;
  localparam int PROG_MAX_MS = 10;
  localparam int HASH_CYCLES = HASH_MAX_MS * CLK_KHZ;
  localparam int PROG_CYCLES = PROG_MAX_MS * CLK_KHZ;
  localparam int CNT_W = 22;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_AUTH_WRITE = 3'h3,
    OP_SETPROT = 3'h4,
    OP_AUTH_SETPROT = 3'h5,
    OP_MAC = 3'h6
  } ppac_op_t;

  typedef enum logic [2:0] {
    ERR_NONE = 3'h0,
    ERR_READ_PROT = 3'h1,
    ERR_WRITE_PROT = 3'h2,
    ERR_AUTH_REQ = 3'h3,
    ERR_MAC_BAD = 3'h4,
    ERR_HASH_TMO = 3'h5,
    ERR_BAD_OP = 3'h6
  } ppac_err_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RD = 6'h02,
    ST_EVAL = 6'h04,
    ST_HASH = 6'h08,
    ST_PROG = 6'h10,
    ST_DONE = 6'h20
  } ppac_state_t;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [BLK_W-1:0] blk;
    logic [WORD_W-1:0] old_data;
    logic [WORD_W-1:0] new_data;
  } ppac_hash_req_t;

endpackage

// ### src/ppac_mem.sv
// User memory: 128 page blocks of 32 bits with a registered read port.
// Assumes no write and read of the same word in one cycle.
`timescale 1ns/1ps
module ppac_mem (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Write port
  input wire logic wr_en,
  input wire logic [ppac_pkg::MADDR_W-1:0] wr_addr,
  input wire logic [ppac_pkg::WORD_W-1:0] wr_data,
  // Read port
  input wire logic [ppac_pkg::MADDR_W-1:0] rd_addr,
  output logic [ppac_pkg::WORD_W-1:0] rd_data_ff
);

  logic [ppac_pkg::WORD_W-1:0] mem [0:ppac_pkg::MEM_WORDS-1];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= ppac_pkg::WORD_RST;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end

endmodule

// ### src/ppac_top.sv
// Page protection access controller in front of the user memory, APB.
// Assumes link framing and the hash engine sit outside this block.
//
// Functional notes
// - Sixteen pages of 256 bits, per-page settings.
// - Protection acts only on its own page.
// - All pages unprotected after reset.
// - Read-protected page refuses user reads.
// - Hash engine still reads protected pages.
// - Write-protected page stays unchanged.
// - One-time mode stores old AND new data.
// - Write protection overrides one-time mode.
// - Authenticated page needs correct MAC to write.
// - After MAC pass, apply write/one-time settings.
// - Authenticated page needs MAC for protection change.
// - 256-bit scratchpad holds secret or challenge.
// - Hash interval from frame end to done.
// - Program interval from frame end to done.
// - Data words are least significant bit first.
// - Programming completes within 10 ms.
// - Writes are one 32-bit page block each.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module ppac_top #(
  parameter int PROG_CYC = ppac_pkg::PROG_CYCLES,
  parameter int HASH_CYC = ppac_pkg::HASH_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Hash engine
  output logic hash_start,
  output ppac_pkg::ppac_hash_req_t hash_req,
  output logic [ppac_pkg::SCR_WORDS*ppac_pkg::WORD_W-1:0] hash_challenge,
  input wire logic [ppac_pkg::MADDR_W-1:0] hash_rd_addr,
  output logic [ppac_pkg::WORD_W-1:0] hash_rd_data,
  input wire logic hash_done,
  input wire logic hash_mac_ok,
  // Interval status
  output logic hash_busy,
  output logic prog_busy
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [ppac_pkg::PROT_W-1:0] prot_of(
    input logic [ppac_pkg::PAGES*ppac_pkg::PROT_W-1:0] v,
    input logic [ppac_pkg::PAGE_W-1:0] pg);
    prot_of = v[pg*ppac_pkg::PROT_W +: ppac_pkg::PROT_W];
  endfunction

  localparam logic [ppac_pkg::CNT_W-1:0] PROG_LOAD =
    ppac_pkg::CNT_W'(PROG_CYC - 1);
  localparam logic [ppac_pkg::CNT_W-1:0] HASH_LOAD =
    ppac_pkg::CNT_W'(HASH_CYC - 1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ppac_pkg::ppac_state_t state_ff, nxt_state;
  ppac_pkg::ppac_op_t op_ff;
  ppac_pkg::ppac_err_t err_ff, nxt_err;
  logic [ppac_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [ppac_pkg::MADDR_W-1:0] addr_ff;
  logic [ppac_pkg::WORD_W-1:0] wdata_ff, rdata_ff, nxt_rdata;
  logic [ppac_pkg::WORD_W-1:0] merged_ff, nxt_merged;
  logic [ppac_pkg::PROT_W-1:0] prot_new_ff;
  logic [ppac_pkg::PAGES*ppac_pkg::PROT_W-1:0] prot_ff, nxt_prot;
  logic [ppac_pkg::SCR_WORDS*ppac_pkg::WORD_W-1:0] scr_ff;
  logic [ppac_pkg::IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat;
  logic nxt_hash_start, mem_we, prot_we;
  logic [ppac_pkg::WORD_W-1:0] mem_rdata, rd_mux;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pwrite & pready;
  wire aligned = (paddr[1:0] == 2'h0);
  wire scr_hit = aligned & (paddr[7:5] == ppac_pkg::OFF_SCR_HI);
  wire reg_hit = aligned & ((paddr <= ppac_pkg::OFF_PROT_CUR) | scr_hit);
  wire idle = (state_ff == ppac_pkg::ST_IDLE);
  wire wr_ctrl = apb_wr & (paddr == ppac_pkg::OFF_CTRL);
  // Operands freeze during a command, so the checked page is the written one.
  wire wr_addr = apb_wr & idle & (paddr == ppac_pkg::OFF_ADDR);
  wire wr_wdata = apb_wr & idle & (paddr == ppac_pkg::OFF_WDATA);
  wire wr_pnew = apb_wr & idle & (paddr == ppac_pkg::OFF_PROT_NEW);
  wire wr_scr = apb_wr & idle & scr_hit;
  wire wr_istat = apb_wr & (paddr == ppac_pkg::OFF_IRQ_STAT);
  wire wr_imask = apb_wr & (paddr == ppac_pkg::OFF_IRQ_MASK);
  wire start_req = wr_ctrl & idle & pwdata[ppac_pkg::CTRL_START_BIT];

  wire [ppac_pkg::PAGE_W-1:0] cur_page =
    addr_ff[ppac_pkg::MADDR_W-1:ppac_pkg::ADDR_PAGE_LSB];
  wire [ppac_pkg::PROT_W-1:0] cur_prot = prot_of(prot_ff, cur_page);
  wire prot_rd = cur_prot[ppac_pkg::PROT_RD_BIT];
  wire prot_wr = cur_prot[ppac_pkg::PROT_WR_BIT];
  wire prot_otp = cur_prot[ppac_pkg::PROT_OTP_BIT];
  wire prot_auth = cur_prot[ppac_pkg::PROT_AUTH_BIT];
  wire op_is_write = (op_ff == ppac_pkg::OP_WRITE) |
                     (op_ff == ppac_pkg::OP_AUTH_WRITE);
  wire [2:0] op_in = pwdata[2:0];
  wire op_valid = (op_in >= 3'(ppac_pkg::OP_READ)) &
                  (op_in <= 3'(ppac_pkg::OP_MAC));

  // One-time mode ANDs with the word read before the hash engine ran.
  wire [ppac_pkg::WORD_W-1:0] old_word =
    hash_busy ? hash_req.old_data : mem_rdata;
  wire [ppac_pkg::WORD_W-1:0] merge_data =
    prot_otp ? (old_word & wdata_ff) : wdata_ff;

  // Only the addressed page's nibble is touched; bits only get set.
  assign nxt_prot = prot_ff |
    ({{(ppac_pkg::PAGES*ppac_pkg::PROT_W-ppac_pkg::PROT_W){1'b0}},
      prot_new_ff} << {cur_page, 2'b00});

  wire ev_done = (state_ff == ppac_pkg::ST_DONE);
  wire ev_err = ev_done & (err_ff != ppac_pkg::ERR_NONE);
  wire [ppac_pkg::IRQ_W-1:0] irq_ev = {ev_err, ev_done};
  wire [ppac_pkg::IRQ_W-1:0] irq_clr =
    wr_istat ? pwdata[ppac_pkg::IRQ_W-1:0] : ppac_pkg::IRQ_RST;
  // A new event in the clearing cycle survives the clear.
  assign nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;

  // ----------------------------------------------------------------------
  // User memory
  // ----------------------------------------------------------------------
  // The hash engine owns the read port while it computes, protection or not.
  wire [ppac_pkg::MADDR_W-1:0] mem_raddr =
    (state_ff == ppac_pkg::ST_HASH) ? hash_rd_addr : addr_ff;

  ppac_mem ppac_mem_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(addr_ff),
    .wr_data(merged_ff),
    .rd_addr(mem_raddr),
    .rd_data_ff(mem_rdata)
  );

  assign hash_rd_data = mem_rdata;

  // ----------------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_err = err_ff;
    nxt_cnt = cnt_ff;
    nxt_rdata = rdata_ff;
    nxt_merged = merged_ff;
    nxt_hash_start = 1'b0;
    mem_we = 1'b0;
    prot_we = 1'b0;
    case (state_ff)
      ppac_pkg::ST_IDLE: begin
        if (start_req) begin
          nxt_err = op_valid ? ppac_pkg::ERR_NONE : ppac_pkg::ERR_BAD_OP;
          nxt_state = op_valid ? ppac_pkg::ST_RD : ppac_pkg::ST_DONE;
        end
      end
      ppac_pkg::ST_RD: nxt_state = ppac_pkg::ST_EVAL;
      ppac_pkg::ST_EVAL: begin
        nxt_state = ppac_pkg::ST_DONE;
        case (op_ff)
          ppac_pkg::OP_READ: begin
            if (prot_rd) begin
              nxt_err = ppac_pkg::ERR_READ_PROT;
            end else begin
              nxt_rdata = mem_rdata;
            end
          end
          ppac_pkg::OP_WRITE, ppac_pkg::OP_SETPROT: begin
            if (prot_auth) begin
              nxt_err = ppac_pkg::ERR_AUTH_REQ;
            end else if (op_is_write && prot_wr) begin
              nxt_err = ppac_pkg::ERR_WRITE_PROT;
            end else begin
              nxt_merged = merge_data;
              nxt_cnt = PROG_LOAD;
              nxt_state = ppac_pkg::ST_PROG;
            end
          end
          default: begin
            nxt_hash_start = 1'b1;
            nxt_cnt = HASH_LOAD;
            nxt_state = ppac_pkg::ST_HASH;
          end
        endcase
      end
      ppac_pkg::ST_HASH: begin
        if (hash_done) begin
          nxt_state = ppac_pkg::ST_DONE;
          if (op_ff == ppac_pkg::OP_MAC) begin
            nxt_err = ppac_pkg::ERR_NONE;
          end else if (!hash_mac_ok) begin
            nxt_err = ppac_pkg::ERR_MAC_BAD;
          end else if (op_is_write && prot_wr) begin
            nxt_err = ppac_pkg::ERR_WRITE_PROT;
          end else begin
            nxt_merged = merge_data;
            nxt_cnt = PROG_LOAD;
            nxt_state = ppac_pkg::ST_PROG;
          end
        end else if (cnt_ff == '0) begin
          nxt_err = ppac_pkg::ERR_HASH_TMO;
          nxt_state = ppac_pkg::ST_DONE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ppac_pkg::ST_PROG: begin
        if (cnt_ff == '0) begin
          mem_we = op_is_write;
          prot_we = ~op_is_write;
          nxt_state = ppac_pkg::ST_DONE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ppac_pkg::ST_DONE: nxt_state = ppac_pkg::ST_IDLE;
      default: nxt_state = ppac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ppac_pkg::ST_IDLE;
      err_ff <= ppac_pkg::ERR_NONE;
      cnt_ff <= '0;
      rdata_ff <= ppac_pkg::WORD_RST;
      merged_ff <= ppac_pkg::WORD_RST;
      hash_start <= 1'b0;
      hash_busy <= 1'b0;
      prog_busy <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      err_ff <= nxt_err;
      cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
      merged_ff <= nxt_merged;
      hash_start <= nxt_hash_start;
      hash_busy <= (nxt_state == ppac_pkg::ST_HASH);
      prog_busy <= (nxt_state == ppac_pkg::ST_PROG);
    end
  end

  // Protection settings stand in for nonvolatile bits; reset models the
  // delivery state.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prot_ff <= ppac_pkg::PROT_RST;
    end else if (prot_we) begin
      prot_ff <= nxt_prot;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hash_req <= '0;
    end else if (nxt_hash_start) begin
      hash_req <= '{page: cur_page, blk: addr_ff[ppac_pkg::BLK_W-1:0],
                    old_data: mem_rdata, new_data: wdata_ff};
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  // Bit 0 of every data word is the first bit on the air.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_ff <= ppac_pkg::OP_NONE;
      addr_ff <= '0;
      wdata_ff <= ppac_pkg::WORD_RST;
      prot_new_ff <= '0;
      irq_mask_ff <= ppac_pkg::IRQ_RST;
    end else begin
      if (wr_ctrl && idle) begin
        op_ff <= ppac_pkg::ppac_op_t'(op_in);
      end
      if (wr_addr) begin
        addr_ff <= pwdata[ppac_pkg::MADDR_W-1:0];
      end
      if (wr_wdata) begin
        wdata_ff <= pwdata;
      end
      if (wr_pnew) begin
        prot_new_ff <= pwdata[ppac_pkg::PROT_W-1:0];
      end
      if (wr_imask) begin
        irq_mask_ff <= pwdata[ppac_pkg::IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scr_ff <= '0;
    end else if (wr_scr) begin
      scr_ff[paddr[4:2]*ppac_pkg::WORD_W +: ppac_pkg::WORD_W] <= pwdata;
    end
  end

  assign hash_challenge = scr_ff;

  always_comb begin
    rd_mux = ppac_pkg::WORD_RST;
    case (paddr)
      ppac_pkg::OFF_CTRL: rd_mux = 32'(op_ff);
      ppac_pkg::OFF_ADDR: rd_mux = 32'(addr_ff);
      ppac_pkg::OFF_WDATA: rd_mux = wdata_ff;
      ppac_pkg::OFF_RDATA: rd_mux = rdata_ff;
      ppac_pkg::OFF_PROT_NEW: rd_mux = 32'(prot_new_ff);
      ppac_pkg::OFF_STATUS: begin
        rd_mux = (32'(!idle) << ppac_pkg::STAT_BUSY_BIT) |
                 (32'(hash_busy) << ppac_pkg::STAT_HASH_BIT) |
                 (32'(prog_busy) << ppac_pkg::STAT_PROG_BIT) |
                 (32'(err_ff) << ppac_pkg::STAT_ERR_LSB);
      end
      ppac_pkg::OFF_IRQ_STAT: rd_mux = 32'(irq_stat_ff);
      ppac_pkg::OFF_IRQ_MASK: rd_mux = 32'(irq_mask_ff);
      ppac_pkg::OFF_PROT_CUR: rd_mux = 32'(prot_of(prot_ff, cur_page));
      default: begin
        if (scr_hit) begin
          rd_mux = scr_ff[paddr[4:2]*ppac_pkg::WORD_W +: ppac_pkg::WORD_W];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // APB answer and interrupt
  // ----------------------------------------------------------------------
  // Zero wait states: ready follows each setup; read data is taken at setup.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= ppac_pkg::WORD_RST;
      pslverr <= 1'b0;
      irq_stat_ff <= ppac_pkg::IRQ_RST;
      irq <= 1'b0;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~reg_hit;
      if (apb_setup) begin
        prdata <= reg_hit ? rd_mux : ppac_pkg::WORD_RST;
      end
      irq_stat_ff <= nxt_irq_stat;
      irq <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

endmodule

// ### test/ppac_hash_model.sv
// Behavioural hash engine that sits beside the access controller.
// Assumes hash_start is a one-cycle pulse and memory reads lag one cycle.
`timescale 1ns/1ps
module ppac_hash_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Request side
  input wire logic hash_start,
  input wire ppac_pkg::ppac_hash_req_t hash_req,
  input wire logic [ppac_pkg::WORD_W-1:0] hash_rd_data,
  input wire logic mac_ok_cfg,
  // Answer side
  output logic [ppac_pkg::MADDR_W-1:0] hash_rd_addr,
  output logic hash_done,
  output logic hash_mac_ok,
  output logic [ppac_pkg::WORD_W-1:0] seen_data
);
  logic [3:0] cnt;
  // The verdict line shows the wrong answer outside the done cycle, so
  // a controller that samples it early is caught.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 4'h0;
      hash_done <= 1'b0;
      hash_mac_ok <= 1'b0;
      hash_rd_addr <= 7'h00;
      seen_data <= 32'h00000000;
    end else begin
      hash_done <= 1'b0;
      hash_mac_ok <= ~mac_ok_cfg;
      if (hash_start) begin
        hash_rd_addr <= {hash_req.page, hash_req.blk};
        cnt <= 4'h6;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h2) begin
          seen_data <= hash_rd_data;
        end
        if (cnt == 4'h1) begin
          hash_done <= 1'b1;
          hash_mac_ok <= mac_ok_cfg;
        end
      end
    end
  end
endmodule

// ### test/ppac_top_checker.sv
// Port-level assertions for the access controller.
// Assumes it is bound to the top module with its interval parameters.
`timescale 1ns/1ps
module ppac_top_checker #(
  parameter int PROG_CYC = 20,
  parameter int HASH_CYC = 50
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic hash_start,
  input wire logic hash_done,
  input wire logic hash_busy,
  input wire logic prog_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Run lengths of the two intervals; a counter avoids long repetitions.
  int prog_cnt_ff, nxt_prog_cnt, hash_cnt_ff, nxt_hash_cnt;
  assign nxt_prog_cnt = prog_busy ? prog_cnt_ff + 1 : 0;
  assign nxt_hash_cnt = hash_busy ? hash_cnt_ff + 1 : 0;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prog_cnt_ff <= 0;
      hash_cnt_ff <= 0;
    end else begin
      prog_cnt_ff <= nxt_prog_cnt;
      hash_cnt_ff <= nxt_hash_cnt;
    end
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("held");
  property p_err_ready; pslverr |-> pready && prdata == 32'h00000000;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("bad error");
  property p_unaligned; psel && !penable && paddr[1:0] != 2'h0 |=> pslverr;
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("no error");
  property p_prog_len; $fell(prog_busy) |-> prog_cnt_ff == PROG_CYC;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("prog length");
  property p_hash_len; hash_cnt_ff <= HASH_CYC + 2; endproperty
  a_hash_len: assert property (p_hash_len) else $error("hash too long");
  property p_hash_end; hash_busy && hash_done |-> ##[1:3] !hash_busy;
  endproperty
  a_hash_end: assert property (p_hash_end) else $error("hash not ended");
  property p_start_pulse; hash_start |=> !hash_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start held");
  property p_start_busy; hash_start |-> hash_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start idle");
  property p_prog_excl; prog_busy |-> !hash_start; endproperty
  a_prog_excl: assert property (p_prog_excl) else $error("start in prog");
endmodule

// ### test/ppac_top_test.sv
// Self-checking bench for the access controller, APB master and hash
// partner. Assumes shortened intervals of 20 and 50 cycles.
`timescale 1ns/1ps
`define CK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module ppac_top_test;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic hash_start, hash_done, hash_mac_ok, hash_busy, prog_busy, ok_cfg;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, hash_rd_data, seen;
  logic [255:0] hash_challenge;
  logic [ppac_pkg::MADDR_W-1:0] hash_rd_addr;
  ppac_pkg::ppac_hash_req_t hash_req;
  int n_fail, n_tests, cyc;
  ppac_top #(.PROG_CYC(20), .HASH_CYC(50)) ppac_top_i (.clk_sys, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .irq,
    .hash_start, .hash_req, .hash_challenge, .hash_rd_addr, .hash_rd_data,
    .hash_done, .hash_mac_ok, .hash_busy, .prog_busy);
  ppac_hash_model ppac_hash_model_i (.clk_sys, .rst, .hash_start, .hash_req,
    .hash_rd_data, .mac_ok_cfg(ok_cfg), .hash_rd_addr, .hash_done,
    .hash_mac_ok, .seen_data(seen));
  // ----------------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] op, input logic [6:0] a,
      input logic [31:0] d, input logic [2:0] ex);
    apb(1'b1, ppac_pkg::OFF_ADDR, {25'h0, a}, rd, er);
    apb(1'b1, ppac_pkg::OFF_WDATA, d, rd, er);
    apb(1'b1, ppac_pkg::OFF_CTRL, {28'h0, 1'b1, op}, rd, er);
    rd = 32'h0;
    for (int k = 0; k < 100 && rd[0] !== 1'b1; k++) begin
      apb(1'b0, ppac_pkg::OFF_IRQ_STAT, 32'h0, rd, er);
    end
    `CK("done", 1'b1, rd[0])
    apb(1'b0, ppac_pkg::OFF_STATUS, 32'h0, rd, er);
    `CK("result", ex, rd[6:4])
    apb(1'b1, ppac_pkg::OFF_IRQ_STAT, 32'h3, rd, er);
  endtask
  task automatic setp(input logic [3:0] pg, input logic [3:0] b,
      input logic [2:0] op, input logic [2:0] ex);
    apb(1'b1, ppac_pkg::OFF_PROT_NEW, {28'h0, b}, rd, er);
    cmd(op, {pg, 3'h0}, 32'h0, ex);
  endtask
  task automatic blk(input logic [6:0] a, input logic [31:0] ex);
    cmd(ppac_pkg::OP_READ, a, 32'h0, 3'h0);
    apb(1'b0, ppac_pkg::OFF_RDATA, 32'h0, rd, er);
    `CK("block", ex, rd)
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    apb(1'b1, 8'h44, 32'h12345678, rd, er);
    apb(1'b0, ppac_pkg::OFF_PROT_CUR, 32'h0, rd, er);
    `CK("prot", 32'h0, rd)
    apb(1'b0, 8'h3C, 32'h0, rd, er);
    `CK("unmapped", 1'b1, er)
    apb(1'b0, 8'h06, 32'h0, rd, er);
    `CK("unaligned", 1'b1, er)
    `CK("scratch", 32'h12345678, hash_challenge[63:32])
    $display("test reset done");
  endtask
  task automatic t_write();
    cmd(ppac_pkg::OP_WRITE, 7'h11, 32'hA5C30001, 3'h0);
    cmd(ppac_pkg::OP_WRITE, 7'h10, 32'h00000012, 3'h0);
    blk(7'h11, 32'hA5C30001);
    cmd(ppac_pkg::OP_WRITE, 7'h18, 32'hF0F0FF00, 3'h0);
    cmd(ppac_pkg::OP_WRITE, 7'h20, 32'hF0F0FF00, 3'h0);
    setp(4'h3, 4'h4, ppac_pkg::OP_SETPROT, 3'h0);
    apb(1'b0, ppac_pkg::OFF_PROT_CUR, 32'h0, rd, er);
    `CK("prot", 32'h4, rd[3:0])
    cmd(ppac_pkg::OP_WRITE, 7'h18, 32'h0F0FF0FF, 3'h0);
    cmd(ppac_pkg::OP_WRITE, 7'h20, 32'h0F0FF0FF, 3'h0);
    blk(7'h18, 32'h0000F000);
    blk(7'h20, 32'h0F0FF0FF);
    $display("test write done");
  endtask
  task automatic t_prot();
    cmd(ppac_pkg::OP_WRITE, 7'h28, 32'h5555AAAA, 3'h0);
    setp(4'h5, 4'h6, ppac_pkg::OP_SETPROT, 3'h0);
    cmd(ppac_pkg::OP_WRITE, 7'h28, 32'h00000000, 3'h2);
    blk(7'h28, 32'h5555AAAA);
    cmd(ppac_pkg::OP_WRITE, 7'h30, 32'h600DF00D, 3'h0);
    setp(4'h6, 4'h1, ppac_pkg::OP_SETPROT, 3'h0);
    cmd(ppac_pkg::OP_READ, 7'h30, 32'h0, 3'h1);
    apb(1'b0, ppac_pkg::OFF_RDATA, 32'h0, rd, er);
    `CK("kept", 32'h5555AAAA, rd)
    cmd(ppac_pkg::OP_MAC, 7'h30, 32'h0, 3'h0);
    `CK("hash in", 32'h600DF00D, seen)
    $display("test protect done");
  endtask
  task automatic t_auth();
    cmd(ppac_pkg::OP_WRITE, 7'h38, 32'hFFFF0000, 3'h0);
    setp(4'h7, 4'h8, ppac_pkg::OP_SETPROT, 3'h0);
    cmd(ppac_pkg::OP_WRITE, 7'h38, 32'h00001234, 3'h3);
    ok_cfg <= 1'b0;
    cmd(ppac_pkg::OP_AUTH_WRITE, 7'h38, 32'h00001234, 3'h4);
    blk(7'h38, 32'hFFFF0000);
    ok_cfg <= 1'b1;
    cmd(ppac_pkg::OP_AUTH_WRITE, 7'h38, 32'h00001234, 3'h0);
    blk(7'h38, 32'h00001234);
    setp(4'h7, 4'h4, ppac_pkg::OP_SETPROT, 3'h3);
    setp(4'h7, 4'h4, ppac_pkg::OP_AUTH_SETPROT, 3'h0);
    cmd(ppac_pkg::OP_AUTH_WRITE, 7'h38, 32'hFFFF0030, 3'h0);
    blk(7'h38, 32'h00000030);
    ok_cfg <= 1'b0;
    setp(4'h7, 4'h2, ppac_pkg::OP_AUTH_SETPROT, 3'h4);
    $display("test auth done");
  endtask
  task automatic t_irq();
    apb(1'b1, ppac_pkg::OFF_IRQ_MASK, 32'h1, rd, er);
    apb(1'b1, ppac_pkg::OFF_CTRL, 32'h0000000F, rd, er);
    repeat (12) @(posedge clk_sys);
    `CK("irq", 1'b1, irq)
    apb(1'b0, ppac_pkg::OFF_STATUS, 32'h0, rd, er);
    `CK("bad op", 3'h6, rd[6:4])
    apb(1'b1, ppac_pkg::OFF_IRQ_MASK, 32'h0, rd, er);
    repeat (2) @(posedge clk_sys);
    `CK("masked", 1'b0, irq)
    apb(1'b1, ppac_pkg::OFF_IRQ_MASK, 32'h1, rd, er);
    apb(1'b1, ppac_pkg::OFF_IRQ_STAT, 32'h3, rd, er);
    repeat (2) @(posedge clk_sys);
    `CK("cleared", 1'b0, irq)
    $display("test irq done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      final_report();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst = 1'b1;
    ok_cfg = 1'b1;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_write();
    t_prot();
    t_auth();
    t_irq();
    final_report();
  end
endmodule
bind ppac_top ppac_top_checker #(.PROG_CYC(PROG_CYC), .HASH_CYC(HASH_CYC))
  ppac_top_checker_i (.clk_sys, .rst, .psel, .penable, .paddr, .pready,
  .prdata, .pslverr, .hash_start, .hash_done, .hash_busy, .prog_busy);
